// ### hw/pbc_pkg.sv
package pbc_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 50;
	localparam int LOCK_TIME_NS = 5_000_000;
	// Least wait, so round up
	localparam int LOCK_WAIT_CYCLES = (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Serial clock half period; must cover the three-stage pin synchroniser
	localparam int SCLK_HALF_CYCLES = 4;

	// ****************************************
	// Device register map (serial control port)
	// ****************************************
	localparam logic [4:0] DEV_STATUS_ADDR = 5'h00;
	localparam logic [4:0] DEV_BAND_ADDR = 5'h08;
	localparam logic [4:0] DEV_DIV_ADDR = 5'h09;
	localparam int DEV_LOCK_BIT = 1;
	localparam int BAND_MSB = 7;
	localparam int BAND_LSB = 2;
	localparam int FIRST_DIV_MSB = 6;
	localparam int FIRST_DIV_LSB = 5;
	localparam int SECOND_DIV_MSB = 4;
	localparam int SECOND_DIV_LSB = 3;
	localparam logic [5:0] BAND_AUTO = 6'h3F;
	localparam logic [5:0] BAND_MAX = 6'h3E;
	localparam logic [5:0] BAND_HIGH_RANGE = 6'h20;
	localparam int INSTR_READ_BIT = 7;

	// ****************************************
	// Temperature thresholds, degrees C
	// ****************************************
	localparam int T_M30 = -30;
	localparam int T_M10 = -10;
	localparam int T_P15 = 15;
	localparam int T_P55 = 55;

	// ****************************************
	// Controller register map (AHB-Lite)
	// ****************************************
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_DIVIDER = 8'h04;
	localparam logic [7:0] REG_TEMP = 8'h08;
	localparam logic [7:0] REG_PRESET = 8'h0C;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_IRQ_STATUS = 8'h14;
	localparam logic [7:0] REG_IRQ_CLEAR = 8'h18;
	localparam logic [7:0] REG_IRQ_ENABLE = 8'h1C;
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_MODE_LSB = 1;
	localparam int CTRL_REF_BIT = 3;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_LOCK_BIT = 1;
	localparam int STAT_STATE_LSB = 2;
	localparam int STAT_RB_LSB = 8;
	localparam int STAT_FINAL_LSB = 16;
	localparam logic [7:0] DIVIDER_RESET = 8'h00;
	localparam logic [7:0] TEMP_RESET = 8'h19;
	localparam logic [5:0] PRESET_RESET = 6'h3D;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_TIMEOUT = 1;
	localparam int IRQ_BADBAND = 2;
	localparam int IRQ_W = 3;

	typedef enum logic [1:0] {
		MODE_CAL_WRITE = 2'b00,
		MODE_CAL_REPORT = 2'b01,
		MODE_LOAD = 2'b10
	} pbc_mode_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_WR_DIV = 3'b001,
		ST_WR_AUTO = 3'b010,
		ST_POLL = 3'b011,
		ST_RD_BAND = 3'b100,
		ST_WR_BAND = 3'b101
	} pbc_state_t;

endpackage : pbc_pkg

// ### hw/pbc_sync.sv
`timescale 1ns/1ps
module pbc_sync #(
	parameter int W = 1
) (
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);
	import pbc_pkg::*;

	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;
	logic [W-1:0] q;
	logic [W-1:0] next_q;

	// Per bit: accept a change only once stages two and three agree
	always_comb begin
		for (int i = 0; i < W; i++) begin
			next_q[i] = (s2[i] == s3[i]) ? s3[i] : q[i];
		end
	end

	// Three-stage chain; s1 feeds s2 only
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			q <= '0;
		end else begin
			s1 <= d_in;
			s2 <= s1;
			s3 <= s2;
			q <= next_q;
		end
	end

	assign q_out = q;

endmodule : pbc_sync

// ### hw/pbc_serial.sv
`timescale 1ns/1ps
module pbc_serial #(
	parameter int HALF = pbc_pkg::SCLK_HALF_CYCLES
) (
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	input wire logic start_in,
	input wire logic read_in,
	input wire logic [4:0] addr_in,
	input wire logic [7:0] wdata_in,
	output logic ready_out,
	output logic done_out,
	output logic [7:0] rdata_out,
	output logic sclk_out,
	output logic cs_n_out,
	output logic sdio_out,
	output logic sdio_oe_out,
	input wire logic sdio_in
);
	import pbc_pkg::*;

	if (HALF < 4 || HALF > 255) begin : g_chk
		$error("pbc_serial: HALF must be 4..255");
	end

	logic active, next_active;
	logic sclk, next_sclk;
	logic [7:0] div, next_div;
	logic [3:0] bit_cnt, next_bit_cnt;
	logic [15:0] tx, next_tx;
	logic [7:0] rx, next_rx;
	logic is_read, next_is_read;
	logic done, next_done;
	logic [7:0] rdata, next_rdata;
	logic tick;

	// ****************************************
	// Frame engine: 8-bit instruction, 8 data bits, MSB first
	// ****************************************
	// Slow rate as a one-cycle enable, not a derived clock
	always_comb begin
		tick = active && (div == 8'(HALF - 1));
		next_active = active;
		next_sclk = sclk;
		next_div = active ? (tick ? 8'h00 : div + 8'h01) : 8'h00;
		next_bit_cnt = bit_cnt;
		next_tx = tx;
		next_rx = rx;
		next_is_read = is_read;
		next_done = 1'b0;
		next_rdata = rdata;
		if (start_in && !active) begin
			next_active = 1'b1;
			next_sclk = 1'b0;
			next_bit_cnt = 4'h0;
			next_tx = {read_in, 2'b00, addr_in, wdata_in};
			next_rx = 8'h00;
			next_is_read = read_in;
		end else if (tick) begin
			if (!sclk) begin
				next_sclk = 1'b1;
			end else begin
				// Sample at the falling edge: a full period covers the synchroniser delay
				next_sclk = 1'b0;
				if (bit_cnt[3]) begin
					next_rx = {rx[6:0], sdio_in};
				end
				if (bit_cnt == 4'hF) begin
					next_active = 1'b0;
					next_done = 1'b1;
					next_rdata = is_read ? {rx[6:0], sdio_in} : 8'h00;
				end else begin
					next_bit_cnt = bit_cnt + 4'h1;
					next_tx = {tx[14:0], 1'b0};
				end
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			active <= 1'b0;
			sclk <= 1'b0;
			div <= 8'h00;
			bit_cnt <= 4'h0;
			tx <= 16'h0000;
			rx <= 8'h00;
			is_read <= 1'b0;
			done <= 1'b0;
			rdata <= 8'h00;
		end else begin
			active <= next_active;
			sclk <= next_sclk;
			div <= next_div;
			bit_cnt <= next_bit_cnt;
			tx <= next_tx;
			rx <= next_rx;
			is_read <= next_is_read;
			done <= next_done;
			rdata <= next_rdata;
		end
	end

	// Line released during read data so the device can drive it
	assign ready_out = !active;
	assign done_out = done;
	assign rdata_out = rdata;
	assign sclk_out = sclk;
	assign cs_n_out = !active;
	assign sdio_out = tx[15];
	assign sdio_oe_out = active && !(is_read && bit_cnt[3]);

endmodule : pbc_serial

// ### hw/pbc_top.sv
//
// Operation
// - Before calibrating, write both divider fields and the other multiplier settings.
// - Writing band code 63 into the band field starts automatic band selection.
// - After lock, read the band field back to get the automatically chosen band.
// - The reference clock must run from divider programming to the final band write.
// - The system temperature is known when automatic selection runs.
// - Bands 0..31 get +2 below -10C, +1 to 15C, 0 to 55C, -1 above.
// - Bands 32..62 get +3 below -30C, +2 to -10C, +1 to 15C, 0 to 55C, -1 above.
// - The adjusted band is written back into the band field, leaving automatic mode.
// - Alternatively the adjusted band is saved and reloaded at every power-up.
// - A fixed guaranteed band may be preloaded for screened parts.
//
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ps
module pbc_top #(
	parameter int LOCK_WAIT_CYC = pbc_pkg::LOCK_WAIT_CYCLES,
	parameter int SCLK_HALF = pbc_pkg::SCLK_HALF_CYCLES
) (
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	// AHB-Lite slave
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic hready_in,
	input wire logic [31:0] hwdata_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out,
	// Interrupt
	output logic irq_out,
	// Device pins
	output logic ref_run_out,
	output logic sclk_out,
	output logic cs_n_out,
	output logic sdio_out,
	output logic sdio_oe_out,
	input wire logic sdio_in,
	input wire logic lock_pin_in
);
	import pbc_pkg::*;

	if (LOCK_WAIT_CYC < 1 || LOCK_WAIT_CYC > 1048575) begin : g_chk
		$error("pbc_top: LOCK_WAIT_CYC out of range");
	end

	// ****************************************
	// Band adjustment
	// ****************************************
	function automatic logic [5:0] pbc_adjust(input logic [5:0] band,
		input logic signed [7:0] temp);
		int off;
		int sum;
		off = 0;
		sum = 0;
		if (band < BAND_HIGH_RANGE) begin
			if (temp < T_M10) begin
				off = 2;
			end else if (temp < T_P15) begin
				off = 1;
			end else if (temp < T_P55) begin
				off = 0;
			end else begin
				off = -1;
			end
		end else begin
			if (temp < T_M30) begin
				off = 3;
			end else if (temp < T_M10) begin
				off = 2;
			end else if (temp < T_P15) begin
				off = 1;
			end else if (temp < T_P55) begin
				off = 0;
			end else begin
				off = -1;
			end
		end
		sum = int'(band) + off;
		// Never produce the automatic code or wrap below zero
		if (sum < 0) begin
			sum = 0;
		end else if (sum > int'(BAND_MAX)) begin
			sum = int'(BAND_MAX);
		end
		return sum[5:0];
	endfunction : pbc_adjust

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic sdio_s;
	logic lock_s;

	pbc_sync #(
		.W(2)
	) u_sync (
		.clk_sys_in(clk_sys_in),
		.nrst_in(nrst_in),
		.d_in({lock_pin_in, sdio_in}),
		.q_out({lock_s, sdio_s})
	);

	// ****************************************
	// Serial control port engine
	// ****************************************
	logic ser_start;
	logic ser_read;
	logic [4:0] ser_addr;
	logic [7:0] ser_wdata;
	logic ser_ready;
	logic ser_done;
	logic [7:0] ser_rdata;

	pbc_serial #(
		.HALF(SCLK_HALF)
	) u_serial (
		.clk_sys_in(clk_sys_in),
		.nrst_in(nrst_in),
		.start_in(ser_start),
		.read_in(ser_read),
		.addr_in(ser_addr),
		.wdata_in(ser_wdata),
		.ready_out(ser_ready),
		.done_out(ser_done),
		.rdata_out(ser_rdata),
		.sclk_out(sclk_out),
		.cs_n_out(cs_n_out),
		.sdio_out(sdio_out),
		.sdio_oe_out(sdio_oe_out),
		.sdio_in(sdio_s)
	);

	// ****************************************
	// AHB-Lite address phase capture
	// ****************************************
	logic a_valid, next_a_valid;
	logic a_write, next_a_write;
	logic [7:0] a_addr, next_a_addr;
	logic wr_en;

	// Zero wait states: the slave never stretches a transfer
	always_comb begin
		next_a_valid = a_valid;
		next_a_write = a_write;
		next_a_addr = a_addr;
		if (hready_in) begin
			next_a_valid = hsel_in && htrans_in[1];
			next_a_write = hwrite_in;
			next_a_addr = haddr_in[7:0];
		end
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			a_valid <= 1'b0;
			a_write <= 1'b0;
			a_addr <= 8'h00;
		end else begin
			a_valid <= next_a_valid;
			a_write <= next_a_write;
			a_addr <= next_a_addr;
		end
	end

	assign wr_en = a_valid && a_write;
	assign hreadyout_out = 1'b1;
	assign hresp_out = 1'b0;

	// ****************************************
	// Software registers
	// ****************************************
	pbc_mode_t mode, next_mode;
	logic ref_on, next_ref_on;
	logic [7:0] divider, next_divider;
	logic signed [7:0] temp, next_temp;
	logic [5:0] preset, next_preset;
	logic [IRQ_W-1:0] irq_en, next_irq_en;
	logic [IRQ_W-1:0] irq_stat, next_irq_stat;
	logic start_req, next_start_req;
	logic [IRQ_W-1:0] ev;
	pbc_state_t state, next_state;

	// Register writes; start is dropped while a sequence runs
	always_comb begin
		next_mode = mode;
		next_ref_on = ref_on;
		next_divider = divider;
		next_temp = temp;
		next_preset = preset;
		next_irq_en = irq_en;
		next_start_req = 1'b0;
		// Set wins over a clear in the same cycle
		next_irq_stat = irq_stat | ev;
		if (wr_en) begin
			unique case (a_addr)
				REG_CTRL: begin
					next_mode = pbc_mode_t'(hwdata_in[CTRL_MODE_LSB +: 2]);
					next_ref_on = hwdata_in[CTRL_REF_BIT];
					next_start_req = hwdata_in[CTRL_START_BIT] && (state == ST_IDLE);
				end
				REG_DIVIDER: next_divider = hwdata_in[7:0];
				REG_TEMP: next_temp = hwdata_in[7:0];
				REG_PRESET: next_preset = hwdata_in[5:0];
				REG_IRQ_CLEAR: next_irq_stat = (irq_stat & ~hwdata_in[IRQ_W-1:0]) | ev;
				REG_IRQ_ENABLE: next_irq_en = hwdata_in[IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			mode <= MODE_CAL_WRITE;
			ref_on <= 1'b0;
			divider <= DIVIDER_RESET;
			temp <= TEMP_RESET;
			preset <= PRESET_RESET;
			irq_en <= '0;
			irq_stat <= '0;
			start_req <= 1'b0;
		end else begin
			mode <= next_mode;
			ref_on <= next_ref_on;
			divider <= next_divider;
			temp <= next_temp;
			preset <= next_preset;
			irq_en <= next_irq_en;
			irq_stat <= next_irq_stat;
			start_req <= next_start_req;
		end
	end

	// ****************************************
	// Calibration sequencer
	// ****************************************
	logic issued, next_issued;
	logic [19:0] timer, next_timer;
	logic [5:0] rb_band, next_rb_band;
	logic [1:0] rb_low, next_rb_low;
	logic [5:0] final_band, next_final_band;

	// Each state but ST_IDLE runs a serial frame, then acts on its completion; ST_POLL repeats its frame until lock or timeout
	always_comb begin
		next_state = state;
		next_issued = issued;
		next_timer = timer;
		next_rb_band = rb_band;
		next_rb_low = rb_low;
		next_final_band = final_band;
		ser_read = 1'b0;
		ser_addr = DEV_BAND_ADDR;
		ser_wdata = 8'h00;
		ev = '0;
		unique case (state)
			ST_IDLE: begin
				ser_addr = DEV_BAND_ADDR;
			end
			ST_WR_DIV: begin
				ser_addr = DEV_DIV_ADDR;
				ser_wdata = divider;
			end
			ST_WR_AUTO: begin
				ser_addr = DEV_BAND_ADDR;
				ser_wdata = {BAND_AUTO, 2'b00};
			end
			ST_POLL: begin
				ser_read = 1'b1;
				ser_addr = DEV_STATUS_ADDR;
			end
			ST_RD_BAND: begin
				ser_read = 1'b1;
				ser_addr = DEV_BAND_ADDR;
			end
			ST_WR_BAND: begin
				ser_addr = DEV_BAND_ADDR;
				ser_wdata = {final_band, rb_low};
			end
			default: ;
		endcase
		ser_start = (state != ST_IDLE) && !issued && ser_ready;
		if (ser_start) begin
			next_issued = 1'b1;
		end
		if (ser_done) begin
			next_issued = 1'b0;
		end
		unique case (state)
			ST_IDLE: begin
				next_timer = 20'h0_0000;
				if (start_req) begin
					// Preset load skips calibration entirely
					if (mode == MODE_LOAD || mode == 2'b11) begin
						next_final_band = (preset > BAND_MAX) ? BAND_MAX : preset;
						next_rb_low = 2'b00;
						next_state = ST_WR_BAND;
					end else begin
						next_state = ST_WR_DIV;
					end
				end
			end
			ST_WR_DIV: begin
				if (ser_done) begin
					next_state = ST_WR_AUTO;
				end
			end
			ST_WR_AUTO: begin
				if (ser_done) begin
					next_timer = 20'h0_0000;
					next_state = ST_POLL;
				end
			end
			ST_POLL: begin
				// Lock by pin or by status bit; give up only after the wait
				if (timer != 20'hF_FFFF) begin
					next_timer = timer + 20'h0_0001;
				end
				if (ser_done) begin
					if (ser_rdata[DEV_LOCK_BIT] || lock_s) begin
						next_state = ST_RD_BAND;
					end else if (timer >= 20'(LOCK_WAIT_CYC)) begin
						ev[IRQ_TIMEOUT] = 1'b1;
						next_state = ST_IDLE;
					end
				end
			end
			ST_RD_BAND: begin
				if (ser_done) begin
					next_rb_band = ser_rdata[BAND_MSB:BAND_LSB];
					next_rb_low = ser_rdata[BAND_LSB-1:0];
					if (ser_rdata[BAND_MSB:BAND_LSB] == BAND_AUTO) begin
						ev[IRQ_BADBAND] = 1'b1;
						next_state = ST_IDLE;
					end else begin
						next_final_band = pbc_adjust(ser_rdata[BAND_MSB:BAND_LSB], temp);
						if (mode == MODE_CAL_WRITE) begin
							next_state = ST_WR_BAND;
						end else begin
							// Software saves the band and loads it later
							ev[IRQ_DONE] = 1'b1;
							next_state = ST_IDLE;
						end
					end
				end
			end
			ST_WR_BAND: begin
				if (ser_done) begin
					ev[IRQ_DONE] = 1'b1;
					next_state = ST_IDLE;
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state <= ST_IDLE;
			issued <= 1'b0;
			timer <= 20'h0_0000;
			rb_band <= 6'h00;
			rb_low <= 2'b00;
			final_band <= 6'h00;
		end else begin
			state <= next_state;
			issued <= next_issued;
			timer <= next_timer;
			rb_band <= next_rb_band;
			rb_low <= next_rb_low;
			final_band <= next_final_band;
		end
	end

	// ****************************************
	// Read mux, interrupt, reference enable
	// ****************************************
	// Unmapped and write-only offsets read zero
	always_comb begin
		hrdata_out = 32'h0000_0000;
		if (a_valid && !a_write) begin
			unique case (a_addr)
				REG_CTRL: begin
					hrdata_out[CTRL_MODE_LSB +: 2] = mode;
					hrdata_out[CTRL_REF_BIT] = ref_on;
				end
				REG_DIVIDER: hrdata_out[7:0] = divider;
				REG_TEMP: hrdata_out[7:0] = temp;
				REG_PRESET: hrdata_out[5:0] = preset;
				REG_STATUS: begin
					hrdata_out[STAT_BUSY_BIT] = (state != ST_IDLE);
					hrdata_out[STAT_LOCK_BIT] = lock_s;
					hrdata_out[STAT_STATE_LSB +: 3] = state;
					hrdata_out[STAT_RB_LSB +: 6] = rb_band;
					hrdata_out[STAT_FINAL_LSB +: 6] = final_band;
				end
				REG_IRQ_STATUS: hrdata_out[IRQ_W-1:0] = irq_stat;
				REG_IRQ_ENABLE: hrdata_out[IRQ_W-1:0] = irq_en;
				default: ;
			endcase
		end
	end

	assign irq_out = |(irq_stat & irq_en);
	// Reference stays on for the whole sequence regardless of software
	assign ref_run_out = ref_on || (state != ST_IDLE);

endmodule : pbc_top

// ### testbench/pbc_top_chk.sv
`timescale 1ns/1ps
module pbc_top_chk #(
	parameter int LOCK_WAIT_CYC = 200,
	parameter int SCLK_HALF = 4
) (
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	input wire logic hreadyout_out,
	input wire logic hresp_out,
	input wire logic irq_out,
	input wire logic ref_run_out,
	input wire logic sclk_out,
	input wire logic cs_n_out,
	input wire logic sdio_out,
	input wire logic sdio_oe_out
);
	logic [4:0] bits;
	logic [7:0] hi_cnt;
	logic rd_frame, sclk_q, rise;
	assign rise = sclk_out & ~sclk_q;
	// Rises per frame, high time and the direction bit of each frame
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			bits <= 5'h00;
			hi_cnt <= 8'h00;
			rd_frame <= 1'b0;
			sclk_q <= 1'b0;
		end else begin
			sclk_q <= sclk_out;
			hi_cnt <= sclk_out ? hi_cnt + 8'h01 : 8'h00;
			bits <= cs_n_out ? 5'h00 : bits + {4'h0, rise};
			if (rise && bits == 5'h00) begin
				rd_frame <= sdio_out;
			end
		end
	end
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!nrst_in);
	a_reset_quiet: assert property ($rose(nrst_in) |-> cs_n_out && !sclk_out && !ref_run_out)
		else $error("serial pins not idle after reset");
	a_bus_okay: assert property (hreadyout_out && !hresp_out)
		else $error("bus not ready or not okay");
	a_sclk_idle: assert property (cs_n_out |-> !sclk_out)
		else $error("serial clock runs outside a frame");
	a_half_period: assert property ($fell(sclk_out) |-> hi_cnt == SCLK_HALF)
		else $error("serial clock high time wrong");
	a_data_stable: assert property (rise && sdio_oe_out |-> $stable(sdio_out))
		else $error("host data moved at the sampling edge");
	a_frame_bits: assert property ($rose(cs_n_out) |-> bits == 5'h10)
		else $error("frame without sixteen bits");
	a_read_turn: assert property (rise && bits >= 5'h08 && rd_frame |-> !sdio_oe_out)
		else $error("host drives during read data");
	a_host_drive: assert property (rise && (bits < 5'h08 || !rd_frame) |-> sdio_oe_out)
		else $error("host not driving its own bits");
	a_ref_running: assert property (!cs_n_out |-> ref_run_out)
		else $error("reference clock stopped during traffic");
endmodule : pbc_top_chk

bind pbc_top pbc_top_chk #(.LOCK_WAIT_CYC(LOCK_WAIT_CYC), .SCLK_HALF(SCLK_HALF)) chk_u (
	.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .hreadyout_out(hreadyout_out),
	.hresp_out(hresp_out), .irq_out(irq_out), .ref_run_out(ref_run_out),
	.sclk_out(sclk_out), .cs_n_out(cs_n_out), .sdio_out(sdio_out), .sdio_oe_out(sdio_oe_out)
);

// ### testbench/pbc_dev_model.sv
`timescale 1ns/1ps
module pbc_dev_model (
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	input wire logic sclk_in,
	input wire logic cs_n_in,
	input wire logic sdio_in,
	input wire logic [5:0] auto_band_in,
	input wire logic [31:0] lock_dly_in,
	output logic sdio_out,
	output logic lock_pin_out,
	output logic [7:0] band_out,
	output logic [7:0] div_out
);
	logic [7:0] status_lock, band_select, divider_config, sh, rd_byte, wr_byte;
	logic [4:0] cnt, addr;
	logic [31:0] lock_cnt;
	logic is_rd, drv, dbit, noise, sclk_q, locking;
	assign wr_byte = {sh[6:0], sdio_in};
	// Released line toggles so a stale bit is never mistaken for data
	assign sdio_out = drv ? dbit : noise;
	assign lock_pin_out = status_lock[1];
	assign band_out = band_select;
	assign div_out = divider_config;
	// Serial slave sampled on the system clock; pins are far slower
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			{status_lock, band_select, divider_config, sh, rd_byte} <= '0;
			{cnt, addr, lock_cnt, is_rd, drv, dbit, noise, sclk_q, locking} <= '0;
		end else begin
			noise <= ~noise;
			sclk_q <= sclk_in;
			if (locking) begin
				if (lock_cnt == 32'h0000_0000) begin
					locking <= 1'b0;
					status_lock[1] <= 1'b1;
					band_select[7:2] <= auto_band_in;
				end else begin
					lock_cnt <= lock_cnt - 32'h0000_0001;
				end
			end
			if (cs_n_in) begin
				cnt <= 5'h00;
				drv <= 1'b0;
			end else if (sclk_in && !sclk_q) begin
				sh <= wr_byte;
				cnt <= cnt + 5'h01;
				if (cnt == 5'h07) begin
					is_rd <= wr_byte[7];
					addr <= wr_byte[4:0];
					rd_byte <= (wr_byte[4:0] == 5'h00) ? status_lock :
						(wr_byte[4:0] == 5'h08) ? band_select :
						(wr_byte[4:0] == 5'h09) ? divider_config : 8'h00;
				end
				if (cnt == 5'h0F && !is_rd && addr == 5'h09) begin
					divider_config <= wr_byte;
				end
				if (cnt == 5'h0F && !is_rd && addr == 5'h08) begin
					band_select <= wr_byte;
					if (wr_byte[7:2] == 6'h3F) begin
						locking <= 1'b1;
						lock_cnt <= lock_dly_in;
						status_lock[1] <= 1'b0;
					end
				end
			end else if (!sclk_in && sclk_q && is_rd && cnt[3]) begin
				drv <= 1'b1;
				dbit <= rd_byte[~cnt[2:0]];
			end
		end
	end
endmodule : pbc_dev_model

// ### testbench/pll_band_calibration_tb.sv
`timescale 1ns/1ps
`define CHK(what, exp, got) begin \
	cmp_count++; \
	if ((got) !== (exp)) begin \
		num_errors++; \
		$display("unexpected %s: expected %h, seen %h", what, exp, got); \
	end \
end
module pll_band_calibration_tb;
	import pbc_pkg::*;
	typedef struct {
		logic [7:0] temp;
		logic [5:0] band;
		logic [1:0] mode;
		logic [5:0] preset;
		logic [31:0] dly;
		logic [5:0] dev;
		logic [5:0] fin;
		logic [2:0] irq;
	} pbc_row_t;
	// temp, auto band, mode, preset, lock delay, device band, final band, irq
	pbc_row_t rows[15] = '{
		'{8'hD8, 6'h0A, 2'h0, 6'h00, 32'h0000_001E, 6'h0C, 6'h0C, 3'h1},
		'{8'hF6, 6'h0A, 2'h0, 6'h00, 32'h0000_0096, 6'h0B, 6'h0B, 3'h1},
		'{8'h0F, 6'h1F, 2'h0, 6'h00, 32'h0000_001E, 6'h1F, 6'h1F, 3'h1},
		'{8'h37, 6'h00, 2'h0, 6'h00, 32'h0000_0096, 6'h00, 6'h00, 3'h1},
		'{8'hE1, 6'h28, 2'h0, 6'h00, 32'h0000_001E, 6'h2B, 6'h2B, 3'h1},
		'{8'hE2, 6'h28, 2'h0, 6'h00, 32'h0000_0096, 6'h2A, 6'h2A, 3'h1},
		'{8'h0E, 6'h20, 2'h0, 6'h00, 32'h0000_001E, 6'h21, 6'h21, 3'h1},
		'{8'hD8, 6'h3E, 2'h0, 6'h00, 32'h0000_001E, 6'h3E, 6'h3E, 3'h1},
		'{8'h55, 6'h20, 2'h0, 6'h00, 32'h0000_0096, 6'h1F, 6'h1F, 3'h1},
		'{8'h19, 6'h3F, 2'h0, 6'h00, 32'h0000_001E, 6'h3F, 6'h00, 3'h4},
		'{8'h19, 6'h10, 2'h0, 6'h00, 32'h0001_86A0, 6'h3F, 6'h00, 3'h2},
		'{8'h00, 6'h14, 2'h1, 6'h00, 32'h0000_001E, 6'h14, 6'h15, 3'h1},
		'{8'h19, 6'h00, 2'h2, 6'h3D, 32'h0000_001E, 6'h3D, 6'h00, 3'h1},
		'{8'h19, 6'h00, 2'h2, 6'h3F, 32'h0000_001E, 6'h3E, 6'h00, 3'h1},
		'{8'h19, 6'h00, 2'h3, 6'h02, 32'h0000_001E, 6'h02, 6'h00, 3'h1}};
	logic [7:0] rst_addr[7] = '{REG_CTRL, REG_DIVIDER, REG_TEMP, REG_PRESET, REG_IRQ_STATUS,
		REG_IRQ_ENABLE, 8'h40};
	logic [7:0] rst_val[7] = '{8'h00, 8'h00, 8'h19, 8'h3D, 8'h00, 8'h00, 8'h00};
	logic clk_sys_in, nrst_in, hsel_in, hwrite_in, hreadyout_out, hresp_out, irq_out;
	logic ref_run_out, sclk_out, cs_n_out, sdio_out, sdio_oe_out, sdio_w, dev_sdio, lock_pin;
	logic [31:0] haddr_in, hwdata_in, hrdata_out, rd_q, rd, lock_dly;
	logic [1:0] htrans_in;
	logic [5:0] auto_band;
	logic [7:0] dev_band, dev_div;
	int num_errors, cmp_count, cycles;
	// Shared data line: host when enabled, else the device model
	assign sdio_w = sdio_oe_out ? sdio_out : dev_sdio;
	pbc_top #(.LOCK_WAIT_CYC(200), .SCLK_HALF(4)) dut_u (
		.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
		.htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'b010),
		.hready_in(hreadyout_out), .hwdata_in(hwdata_in), .hrdata_out(hrdata_out),
		.hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .irq_out(irq_out),
		.ref_run_out(ref_run_out), .sclk_out(sclk_out), .cs_n_out(cs_n_out),
		.sdio_out(sdio_out), .sdio_oe_out(sdio_oe_out), .sdio_in(sdio_w), .lock_pin_in(lock_pin));
	pbc_dev_model dev_u (
		.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .sclk_in(sclk_out), .cs_n_in(cs_n_out),
		.sdio_in(sdio_w), .auto_band_in(auto_band), .lock_dly_in(lock_dly), .sdio_out(dev_sdio),
		.lock_pin_out(lock_pin), .band_out(dev_band), .div_out(dev_div));
	initial begin
		clk_sys_in = 1'b0;
		forever #25 clk_sys_in = ~clk_sys_in;
	end
	// Read data captured at the edge that ends the data phase
	always @(posedge clk_sys_in) begin
		rd_q <= hrdata_out;
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			num_errors++;
			stop_test();
		end
	end
	task automatic stop_test;
		$display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : stop_test
	// One single word transfer; waits on ready in both phases
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_sys_in);
		hsel_in <= 1'b1;
		htrans_in <= 2'b10;
		haddr_in <= 32'(a);
		hwrite_in <= wr;
		do @(posedge clk_sys_in); while (hreadyout_out !== 1'b1 && ++n < 50);
		hsel_in <= 1'b0;
		htrans_in <= 2'b00;
		hwdata_in <= wd;
		do @(posedge clk_sys_in); while (hreadyout_out !== 1'b1 && ++n < 50);
		#1;
		q = rd_q;
	endtask : bus
	task automatic wait_idle;
		int n;
		n = 0;
		rd = 32'h0000_0001;
		while (rd[0] !== 1'b0 && n++ < 3000) bus(1'b0, REG_STATUS, 32'h0000_0000, rd);
		`CHK("busy", 1'b0, rd[0])
	endtask : wait_idle
	task automatic do_reset;
		@(posedge clk_sys_in);
		nrst_in <= 1'b0;
		repeat (2) @(posedge clk_sys_in);
		nrst_in <= 1'b1;
	endtask : do_reset
	// ****************
	// Main sequence
	// ****************
	initial begin
		{nrst_in, hsel_in, hwrite_in, htrans_in, haddr_in, hwdata_in} = '0;
		{num_errors, cmp_count, auto_band, lock_dly} = '0;
		repeat (2) @(posedge clk_sys_in);
		nrst_in <= 1'b1;
		bus(1'b1, REG_IRQ_ENABLE, 32'h0000_0007, rd);
		foreach (rows[i]) begin
			auto_band <= rows[i].band;
			lock_dly <= rows[i].dly;
			bus(1'b1, REG_DIVIDER, 32'h0000_0068, rd);
			bus(1'b1, REG_TEMP, 32'(rows[i].temp), rd);
			bus(1'b1, REG_PRESET, 32'(rows[i].preset), rd);
			bus(1'b1, REG_CTRL, {29'h0, rows[i].mode, 1'b1}, rd);
			wait_idle();
			`CHK("device band", rows[i].dev, dev_band[7:2])
			`CHK("device divider", 8'h68, dev_div)
			bus(1'b0, REG_STATUS, 32'h0000_0000, rd);
			if (rows[i].irq == 3'h1 && !rows[i].mode[1]) `CHK("final band", rows[i].fin, rd[21:16])
			bus(1'b0, REG_IRQ_STATUS, 32'h0000_0000, rd);
			`CHK("irq status", rows[i].irq, rd[2:0])
			`CHK("irq line", 1'b1, irq_out)
			bus(1'b1, REG_IRQ_CLEAR, 32'h0000_0007, rd);
			`CHK("irq cleared", 1'b0, irq_out)
			$display("row %0d done", i);
		end
		// Masked event stays pending; status ignores writes
		bus(1'b1, REG_IRQ_ENABLE, 32'h0000_0000, rd);
		bus(1'b1, REG_CTRL, 32'h0000_0005, rd);
		wait_idle();
		`CHK("masked line", 1'b0, irq_out)
		bus(1'b1, REG_IRQ_STATUS, 32'h0000_0000, rd);
		bus(1'b0, REG_IRQ_STATUS, 32'h0000_0000, rd);
		`CHK("sticky status", 3'h1, rd[2:0])
		bus(1'b1, REG_IRQ_ENABLE, 32'h0000_0001, rd);
		`CHK("unmasked line", 1'b1, irq_out)
		bus(1'b1, REG_CTRL, 32'h0000_0008, rd);
		`CHK("reference run", 1'b1, ref_run_out)
		$display("mask test done");
		// Reset in mid calibration, then load the preset band from its reset value
		bus(1'b1, REG_CTRL, 32'h0000_0001, rd);
		repeat (40) @(posedge clk_sys_in);
		do_reset();
		@(posedge clk_sys_in);
		`CHK("reset frame", 1'b1, cs_n_out)
		bus(1'b1, 8'h40, 32'hFFFF_FFFF, rd);
		foreach (rst_addr[i]) begin
			bus(1'b0, rst_addr[i], 32'h0000_0000, rd);
			`CHK("reset value", 32'(rst_val[i]), rd)
		end
		bus(1'b1, REG_CTRL, 32'h0000_0005, rd);
		wait_idle();
		`CHK("reloaded band", 6'h3D, dev_band[7:2])
		$display("reset test done");
		stop_test();
	end
endmodule : pll_band_calibration_tb
